// *** rtl/spi_defines.svh ***
// Register offsets, field positions, reset values and widths of the serial port unit
`ifndef SPI_DEFINES_SVH
`define SPI_DEFINES_SVH

// Byte addresses on the register bus, one aligned word each
`define OFS_CONTROL_ONE 5'h00
`define OFS_CONTROL_TWO 5'h04
`define OFS_BIT_RATE 5'h08
`define OFS_FLAG_STATUS 5'h0c
`define OFS_COMPARE 5'h10
`define OFS_SHIFT_DATA 5'h14

// Control one fields
`define C1_RX_FAULT_IRQ_EN 7
`define C1_UNIT_ENABLE 6
`define C1_TX_EMPTY_IRQ_EN 5
`define C1_MASTER_SELECT 4
`define C1_CLOCK_POLARITY 3
`define C1_CLOCK_PHASE 2
`define C1_SELECT_OUTPUT_EN 1
`define C1_LSB_FIRST 0

// Control two fields
`define C2_MATCH_IRQ_EN 7
`define C2_FAULT_DETECT_EN 4
`define C2_SHARED_PIN_OUTPUT_EN 3
`define C2_STOP_IN_WAIT 1
`define C2_SINGLE_PIN_MODE 0
`define C2_WRITABLE 8'h9b

// Bit rate fields
`define BR_PRESCALE_HI 6
`define BR_PRESCALE_LO 4
`define BR_RATE_HI 3
`define BR_RATE_LO 0
`define BR_WRITABLE 8'h7f

// Status fields
`define ST_RX_FULL 7
`define ST_MATCH 6
`define ST_TX_EMPTY 5
`define ST_FAULT 4

// Reset values
`define RST_CONTROL_ONE 8'h04
`define RST_CONTROL_TWO 8'h00
`define RST_BIT_RATE 8'h00
`define RST_COMPARE 8'h00

// Half bit period counter width: prescale 8 times 2 to the 15th is 2 to the 18th
`define DIV_W 19
`define LAST_EDGE 4'hf
`define LAST_BIT 3'h7

`endif

// *** rtl/spi_pkg.sv ***
// Types shared by the serial port unit and its bench
package spi_pkg;

  // One bit per serial pin: clock, master out, master in, select
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss;
  } pins_t;

  typedef enum logic [0:0] {XFER_IDLE, XFER_RUN} xfer_state_t;

endpackage

// *** rtl/spi_master_slave_port.sv ***
// Byte-wide serial peripheral port, master or slave, with an Avalon-MM register slave
//
// The address map and the Avalon-MM register port are this design's own decisions.
`include "spi_defines.svh"

module spi_master_slave_port (
  input wire logic clk, // 20 MHz bus clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [4:0] address, // Byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire logic wait_mode, // Processor wait mode, same clock
  input wire spi_pkg::pins_t pin_in, // Pin levels seen from outside
  output spi_pkg::pins_t pin_out, // Pin drive values
  output spi_pkg::pins_t pin_oe_n, // Pin output enables, low drives
  output logic irq // Interrupt request
);

  // Bus slave state
  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  // Registers
  logic [7:0] ctl1_ff, ctl2_ff, baud_ff, cmp_ff, tx_buf_ff, rx_buf_ff, sh_ff;
  logic rx_full_ff, match_ff, tx_empty_ff, fault_ff;
  logic arm_rx_ff, arm_match_ff, arm_tx_ff, arm_fault_ff;
  // Serial engine
  spi_pkg::pins_t sync1_ff, sync2_ff, oe_n_ff;
  spi_pkg::xfer_state_t state_ff;
  logic [3:0] edge_cnt_ff;
  logic [2:0] bit_cnt_ff;
  logic [`DIV_W-1:0] div_cnt_ff;
  logic sclk_ff, out_bit_ff, sclk_prev_ff, ss_prev_ff, ss_out_ff, irq_ff;

  // One-hot register decode, shared by reads and writes
  function automatic logic [5:0] decode(input logic [4:0] a);
    logic [5:0] hit;
    hit = 6'h00;
    unique case (a)
      `OFS_CONTROL_ONE: hit[0] = 1'b1;
      `OFS_CONTROL_TWO: hit[1] = 1'b1;
      `OFS_BIT_RATE: hit[2] = 1'b1;
      `OFS_FLAG_STATUS: hit[3] = 1'b1;
      `OFS_COMPARE: hit[4] = 1'b1;
      `OFS_SHIFT_DATA: hit[5] = 1'b1;
      default: hit = 6'h00;
    endcase
    return hit;
  endfunction

  // Bit that leaves the shift register next
  function automatic logic top_bit(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  // Shift one received bit in at the end opposite the outgoing one
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Control fields
  logic en, is_master, clock_polarity, clock_phase, soe, lsb, single, frozen;
  assign en = ctl1_ff[`C1_UNIT_ENABLE];
  assign is_master = ctl1_ff[`C1_MASTER_SELECT];
  assign clock_polarity = ctl1_ff[`C1_CLOCK_POLARITY];
  assign clock_phase = ctl1_ff[`C1_CLOCK_PHASE];
  assign soe = ctl1_ff[`C1_SELECT_OUTPUT_EN];
  assign lsb = ctl1_ff[`C1_LSB_FIRST];
  assign single = ctl2_ff[`C2_SINGLE_PIN_MODE];
  // Master clock generation halts in wait mode only when asked to
  assign frozen = wait_mode & ctl2_ff[`C2_STOP_IN_WAIT];

  // Bus access happens at the edge where waitrequest is seen low
  logic bus_acc, wr_go, rd_go;
  logic [5:0] hit;
  assign bus_acc = (read | write) & ~waitrequest_ff;
  assign wr_go = write & bus_acc & byteenable[0];
  assign rd_go = read & bus_acc;
  assign hit = decode(address);

  logic [7:0] status;
  assign status = {rx_full_ff, match_ff, tx_empty_ff, fault_ff, 4'h0};

  // Half bit period in bus cycles: (prescale + 1) << rate, full period twice that
  logic [`DIV_W-1:0] half_period;
  assign half_period = `DIV_W'({1'b0, baud_ff[`BR_PRESCALE_HI:`BR_PRESCALE_LO]} + 4'h1)
                       << baud_ff[`BR_RATE_HI:`BR_RATE_LO];

  // Synchronised pin levels; only the second stage is read
  logic sclk_s, ss_s, din;
  assign sclk_s = sync2_ff.sclk;
  assign ss_s = sync2_ff.ss;
  assign din = single ? (is_master ? sync2_ff.mosi : sync2_ff.miso)
                      : (is_master ? sync2_ff.miso : sync2_ff.mosi);

  // Edge events for master (divider ticks) and slave (pin transitions)
  logic tick, slave_active, s_edge, s_lead, lead, trail, sample_ev, drive_ev, byte_done;
  assign tick = (state_ff == spi_pkg::XFER_RUN) & is_master & ~frozen
                & (div_cnt_ff == '0);
  assign slave_active = en & ~is_master & ~ss_s & ~fault_ff;
  assign s_edge = slave_active & (sclk_s != sclk_prev_ff);
  assign s_lead = s_edge & (sclk_s != clock_polarity);
  assign lead = is_master ? (tick & ~edge_cnt_ff[0]) : s_lead;
  assign trail = is_master ? (tick & edge_cnt_ff[0]) : (s_edge & ~s_lead);
  // Phase 1 drives on the leading edge, so the first edge opens bit one
  assign sample_ev = clock_phase ? trail : lead;
  assign drive_ev = clock_phase ? lead : trail;
  assign byte_done = sample_ev & (bit_cnt_ff == `LAST_BIT);

  logic [7:0] rx_byte, load_val;
  logic copy, fault_ev, m_start, s_start, load;
  assign rx_byte = shift_in(sh_ff, din, lsb);
  // A full receive buffer at byte end drops the new byte
  assign copy = byte_done & ~rx_full_ff;
  assign fault_ev = en & is_master & ctl2_ff[`C2_FAULT_DETECT_EN] & ~soe & ~ss_s;
  assign m_start = en & is_master & (state_ff == spi_pkg::XFER_IDLE) & ~tx_empty_ff
                   & ~fault_ff & ~frozen & ~fault_ev;
  assign s_start = slave_active & ss_prev_ff;
  assign load = m_start | s_start | (~is_master & byte_done);
  // An empty buffer makes the slave echo what it last received
  assign load_val = ~tx_empty_ff ? tx_buf_ff : (byte_done ? rx_byte : sh_ff);

  // Input synchronisers for all four pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      sclk_prev_ff <= 1'b1; // Matches the synchroniser reset, so no false edge follows
      ss_prev_ff <= 1'b1;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sclk_prev_ff <= sync2_ff.sclk;
      ss_prev_ff <= sync2_ff.ss;
    end
  end

  // Avalon slave: waitrequest drops one cycle after a request, data stands with it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= 32'h0000_0000;
    end else begin
      waitrequest_ff <= ~((read | write) & waitrequest_ff);
      if (read & waitrequest_ff) begin
        unique case (1'b1)
          hit[0]: readdata_ff <= {24'h00_0000, ctl1_ff};
          hit[1]: readdata_ff <= {24'h00_0000, ctl2_ff};
          hit[2]: readdata_ff <= {24'h00_0000, baud_ff};
          hit[3]: readdata_ff <= {24'h00_0000, status};
          hit[4]: readdata_ff <= {24'h00_0000, cmp_ff};
          hit[5]: readdata_ff <= {24'h00_0000, rx_buf_ff};
          default: readdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers; a fault overrides a write in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl1_ff <= `RST_CONTROL_ONE;
      ctl2_ff <= `RST_CONTROL_TWO;
      baud_ff <= `RST_BIT_RATE;
      cmp_ff <= `RST_COMPARE;
    end else begin
      if (wr_go & hit[0]) ctl1_ff <= writedata[7:0];
      if (wr_go & hit[1]) ctl2_ff <= writedata[7:0] & `C2_WRITABLE;
      if (wr_go & hit[2]) baud_ff <= writedata[7:0] & `BR_WRITABLE;
      if (wr_go & hit[4]) cmp_ff <= writedata[7:0];
      if (fault_ev) begin
        ctl1_ff[`C1_MASTER_SELECT] <= 1'b0;
        ctl2_ff[`C2_SHARED_PIN_OUTPUT_EN] <= 1'b0;
      end
    end
  end

  // Transmit buffer takes a byte only after the status read saw it empty
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_buf_ff <= 8'h00;
    end else if (wr_go & hit[5] & tx_empty_ff & arm_tx_ff) begin
      tx_buf_ff <= writedata[7:0];
    end
  end

  // Receive buffer copy, only when the previous byte was collected
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_buf_ff <= 8'h00;
    end else if (copy) begin
      rx_buf_ff <= rx_byte;
    end
  end

  // Status flags: clears come first so a same-cycle set wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_full_ff <= 1'b0;
      match_ff <= 1'b0;
      tx_empty_ff <= 1'b1;
      fault_ff <= 1'b0;
    end else begin
      if (rd_go & hit[5] & arm_rx_ff) rx_full_ff <= 1'b0;
      if (rd_go & hit[5] & arm_match_ff) match_ff <= 1'b0;
      if (wr_go & hit[5] & tx_empty_ff & arm_tx_ff) tx_empty_ff <= 1'b0;
      if (wr_go & hit[0] & arm_fault_ff) fault_ff <= 1'b0;
      if (copy) rx_full_ff <= 1'b1;
      if (copy & (rx_byte == cmp_ff)) match_ff <= 1'b1;
      if (load & ~tx_empty_ff) tx_empty_ff <= 1'b1;
      if (fault_ev) fault_ff <= 1'b1;
    end
  end

  // Clear sequences: a status read arms each flag it sees set
  always_ff @(posedge clk) begin
    if (!rstn) begin
      arm_rx_ff <= 1'b0;
      arm_match_ff <= 1'b0;
      arm_tx_ff <= 1'b0;
      arm_fault_ff <= 1'b0;
    end else if (rd_go & hit[3]) begin
      arm_rx_ff <= rx_full_ff;
      arm_match_ff <= match_ff;
      arm_tx_ff <= tx_empty_ff;
      arm_fault_ff <= fault_ff;
    end else begin
      if (rd_go & hit[5]) arm_rx_ff <= 1'b0;
      if (rd_go & hit[5]) arm_match_ff <= 1'b0;
      if (wr_go & hit[5]) arm_tx_ff <= 1'b0;
      if (wr_go & hit[0]) arm_fault_ff <= 1'b0;
    end
  end

  // Master sequencer: sixteen clock edges per byte, aborted by fault or disable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= spi_pkg::XFER_IDLE;
      edge_cnt_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        spi_pkg::XFER_IDLE: begin
          edge_cnt_ff <= 4'h0;
          if (m_start) state_ff <= spi_pkg::XFER_RUN;
        end
        spi_pkg::XFER_RUN: begin
          if (fault_ev | ~en | ~is_master) begin
            state_ff <= spi_pkg::XFER_IDLE;
          end else if (tick) begin
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
            if (edge_cnt_ff == `LAST_EDGE) state_ff <= spi_pkg::XFER_IDLE;
          end
        end
      endcase
    end
  end

  // Bit rate divider; held while frozen so the transfer resumes intact
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_cnt_ff <= '0;
    end else if (state_ff == spi_pkg::XFER_IDLE || div_cnt_ff == '0) begin
      if (!frozen) div_cnt_ff <= half_period - `DIV_W'(1);
    end else if (!frozen) begin
      div_cnt_ff <= div_cnt_ff - `DIV_W'(1);
    end
  end

  // Serial clock: idles at the polarity level, toggles on each tick
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclk_ff <= 1'b0;
    end else if (state_ff == spi_pkg::XFER_RUN && is_master && en) begin
      if (tick) sclk_ff <= ~sclk_ff;
    end else begin
      sclk_ff <= clock_polarity;
    end
  end

  // Shift register, bit counter and outgoing bit, shared by both roles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      out_bit_ff <= 1'b0;
    end else begin
      if (load) begin
        sh_ff <= load_val;
        if (!clock_phase) out_bit_ff <= top_bit(load_val, lsb);
      end else begin
        if (sample_ev) sh_ff <= rx_byte;
        if (drive_ev) out_bit_ff <= top_bit(sh_ff, lsb);
      end
      // Slave deselect or a fresh start throws away a partial byte
      if (m_start | s_start | (~is_master & ~slave_active)) begin
        bit_cnt_ff <= 3'h0;
      end else if (sample_ev) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // Automatic select output, low for the whole master transfer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ss_out_ff <= 1'b1;
    end else begin
      // Released together with the clock drive when the unit is disabled mid-byte
      ss_out_ff <= ~(m_start | (state_ff == spi_pkg::XFER_RUN & en & is_master
                                & ~fault_ev));
    end
  end

  // Output enables; a fault floats every pin until it is cleared
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oe_n_ff <= '1;
    end else begin
      oe_n_ff.sclk <= ~(en & is_master & ~fault_ff & ~fault_ev);
      oe_n_ff.mosi <= ~(en & is_master & ~fault_ff & ~fault_ev
                        & (~single | ctl2_ff[`C2_SHARED_PIN_OUTPUT_EN]));
      oe_n_ff.miso <= ~(slave_active & ~single
                        | slave_active & ctl2_ff[`C2_SHARED_PIN_OUTPUT_EN]);
      oe_n_ff.ss <= ~(en & is_master & ~fault_ff & ~fault_ev
                      & ctl2_ff[`C2_FAULT_DETECT_EN] & soe);
    end
  end

  // Interrupt request from enabled flags, only while the unit is enabled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= en & ((ctl1_ff[`C1_RX_FAULT_IRQ_EN] & (rx_full_ff | fault_ff))
                | (ctl1_ff[`C1_TX_EMPTY_IRQ_EN] & tx_empty_ff)
                | (ctl2_ff[`C2_MATCH_IRQ_EN] & match_ff));
    end
  end

  // Every output straight from a flip-flop
  assign readdata = readdata_ff;
  assign waitrequest = waitrequest_ff;
  assign pin_out = '{sclk: sclk_ff, mosi: out_bit_ff, miso: out_bit_ff, ss: ss_out_ff};
  assign pin_oe_n = oe_n_ff;
  assign irq = irq_ff;

endmodule

// *** verif/spi_master_slave_port_properties.sv ***
// Concurrent checks on the serial port unit's register bus and pins
module spi_master_slave_port_properties (
  input wire logic clk, // Bus clock
  input wire logic rstn, // Reset, active low
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [31:0] readdata, // Read data
  input wire logic waitrequest, // Wait request
  input wire spi_pkg::pins_t pin_out, // Pin drive values
  input wire spi_pkg::pins_t pin_oe_n // Pin enables, low drives
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic [4:0] edges_ff;

  // Clock edges since select fell; saturates so a runaway clock still trips
  always_ff @(posedge clk) begin
    if (!rstn || pin_out.ss) begin
      edges_ff <= 5'h00;
    end else if ($changed(pin_out.sclk) && edges_ff != 5'h1f) begin
      edges_ff <= edges_ff + 5'h01;
    end
  end

  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence

  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered in one cycle");
  property p_ack_cause;
    !waitrequest |-> $past(read || write);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_rd_hi;
    !waitrequest |-> readdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  property p_rd_hold;
    waitrequest |-> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved between reads");
  property p_sclk_idle;
    pin_out.ss && $past(pin_out.ss) |-> $stable(pin_out.sclk);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock moved out of frame");
  property p_edges;
    $rose(pin_out.ss) && !pin_oe_n.sclk |-> edges_ff == 5'h10;
  endproperty
  a_edges: assert property (p_edges) else $error("frame did not hold sixteen edges");
  // Inside a frame the data bit only moves together with a serial clock edge
  property p_data_edge;
    !pin_out.ss && !$past(pin_out.ss) && $changed(pin_out.mosi) |-> $changed(pin_out.sclk);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data bit moved off a clock edge");
  property p_sel_drv;
    !pin_out.ss |-> !pin_oe_n.sclk;
  endproperty
  a_sel_drv: assert property (p_sel_drv) else $error("frame without clock drive");
  c_frame: cover property ($rose(pin_out.ss) && edges_ff == 5'h10);
endmodule

bind spi_master_slave_port spi_master_slave_port_properties u_props (.clk(clk), .rstn(rstn),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// *** verif/spi_far_slave.sv ***
// Behavioural far-side slave, clock idling low, driving on leading and sampling on trailing edge
module spi_far_slave (
  input wire logic sclk, // Serial clock wire
  input wire logic mosi, // Data from the unit
  input wire logic sel_n, // Select wire, active low
  input wire logic lsb_first, // Bit order of both directions
  input wire logic [7:0] tx_byte, // Byte to return
  output logic miso, // Data to the unit
  output logic [7:0] rx_byte, // Last whole byte received
  output int rx_count // Whole bytes received
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  logic [7:0] sh = 8'h00;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    rx_count = 0;
  end
  // Restart the bit count at each select
  always @(negedge sel_n) n = 0;
  // Released line shows the inverse of its last level, never a stale bit
  always @(posedge sel_n) miso = ~miso;
  // Next bit goes out on the leading edge
  always @(posedge sclk) if (!sel_n) miso = lsb_first ? tx_byte[n] : tx_byte[7 - n];
  // Sample on the trailing edge; eight bits make a byte
  always @(negedge sclk) begin
    if (!sel_n) begin
      sh = lsb_first ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      n = n + 1;
      if (n == 8) begin
        rx_byte = sh;
        rx_count = rx_count + 1;
        n = 0;
      end
    end
  end
endmodule

// *** verif/test_spi_master_slave_port.sv ***
// Self-checking bench of the serial port unit as master against a far-side slave
`include "spi_defines.svh"
module test_spi_master_slave_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, read, write, wait_mode, irq, waitrequest, ss_ext, lsb, sclk_d, far_miso;
  logic sclk_w, mosi_w, ss_w, miso_w, hold_sclk;
  logic [4:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic [7:0] far_tx, far_rx, tx, br, keep;
  spi_pkg::pins_t pin_in, pin_out, pin_oe_n;
  logic [31:0] exp_q[$];
  int err_total, comparisons, cycles, half, run, far_count, wt;
  logic [7:0] rv [7] = '{`RST_CONTROL_ONE, `RST_CONTROL_TWO, `RST_BIT_RATE, 8'h20,
    `RST_COMPARE, 8'h00, 8'h00};
  logic [4:0] wo [5] = '{5'h04, 5'h08, 5'h0c, 5'h10, 5'h18};
  logic [7:0] we [5] = '{8'h9b, 8'h7f, 8'h20, 8'hff, 8'h00};

  // Wires: clock and data pulled low when released, select taken from ss_ext when released
  assign sclk_w = pin_oe_n.sclk ? 1'b0 : pin_out.sclk;
  assign mosi_w = pin_oe_n.mosi ? 1'b0 : pin_out.mosi;
  assign miso_w = pin_oe_n.miso ? far_miso : pin_out.miso;
  assign ss_w = pin_oe_n.ss ? ss_ext : pin_out.ss;
  assign pin_in = {sclk_w, mosi_w, miso_w, ss_w};

  spi_master_slave_port u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .wait_mode(wait_mode), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq));
  spi_far_slave u_far (.sclk(sclk_w), .mosi(mosi_w), .sel_n(ss_w), .lsb_first(lsb),
    .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx), .rx_count(far_count));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One bus access held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h000000, d};
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, a, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Read answers against the oldest note
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
      check(readdata, exp_q.pop_front()); // Register value
    end
  end
  // Half period of the serial clock, and the hang limit
  always @(posedge clk) begin
    sclk_d <= pin_out.sclk;
    run <= (pin_out.sclk !== sclk_d) ? 1 : run + 1;
    if (pin_out.sclk !== sclk_d) half <= run;
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {rstn, read, write, wait_mode} <= 4'h0;
    lsb = 1'b0;
    address <= 5'h00;
    writedata <= 32'h0;
    byteenable <= 4'h1;
    ss_ext = 1'b1;
    far_tx = 8'h00;
    keep = 8'h00;
    void'($urandom(32'hb0df));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values, then an unmapped place
    for (int i = 0; i < 7; i++) rd(5'(i * 4), rv[i]); // Reset table
    // All ones into writable, read-only and unmapped places
    foreach (wo[i]) begin
      bus(1'b1, wo[i], 8'hff);
      rd(wo[i], we[i]); // Masked bits
    end
    // A write with the low byte lane off is answered but must not land
    byteenable <= 4'h0;
    bus(1'b1, `OFS_COMPARE, 8'h00);
    byteenable <= 4'h1;
    rd(`OFS_COMPARE, 8'hff); // Lane off keeps the value
    // Match requests, fault detection, and clock stop in wait mode
    bus(1'b1, `OFS_CONTROL_TWO, 8'h92);
    // Three bytes: msb first, lsb first slower, then one lost while the buffer is full
    for (int i = 0; i < 3; i++) begin
      lsb = (i == 1);
      br = (i == 1) ? 8'h12 : 8'h02;
      tx = 8'($urandom);
      far_tx = 8'($urandom);
      if (i != 2) keep = far_tx;
      bus(1'b1, `OFS_CONTROL_ONE, {7'h2b, lsb});
      bus(1'b1, `OFS_BIT_RATE, br);
      bus(1'b1, `OFS_COMPARE, keep);
      check(32'(irq), 32'(i == 2)); // Masked empty flag
      rd(`OFS_FLAG_STATUS, (i == 2) ? 8'he0 : 8'h20); // Empty before write
      bus(1'b1, `OFS_SHIFT_DATA, tx);
      wt = 0;
      while (pin_out.ss !== 1'b0 && wt < 100) begin
        @(posedge clk);
        wt++;
      end
      // Last byte: wait mode freezes the master clock mid-frame, then lets it resume
      if (i == 2) begin
        wait_mode <= 1'b1;
        repeat (3) @(posedge clk);
        hold_sclk = pin_out.sclk;
        repeat (20) @(posedge clk);
        check(32'(pin_out.sclk), 32'(hold_sclk)); // Clock held in wait
        wait_mode <= 1'b0;
      end
      while (pin_out.ss !== 1'b1 && wt < 1000) begin
        @(posedge clk);
        wt++;
      end
      repeat (2) @(posedge clk);
      check(32'(half), 32'({1'b0, br[6:4]} + 4'h1) << br[3:0]); // Rate
      check(32'(far_rx), 32'(tx)); // Byte out
      check(32'(far_count), 32'(i + 1)); // One whole byte a frame
      check(32'(irq), 32'h1); // Match request
      rd(`OFS_FLAG_STATUS, 8'he0); // Full and match
      if (i != 1) rd(`OFS_SHIFT_DATA, keep); // Byte in or overrun
    end
    // Another master pulls select low while fault detection is on
    bus(1'b1, `OFS_CONTROL_ONE, 8'h54);
    ss_ext <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'(pin_oe_n), 32'hf); // Pins float
    rd(`OFS_FLAG_STATUS, 8'h30); // Fault flag
    rd(`OFS_CONTROL_ONE, 8'h44); // Back to slave
    ss_ext <= 1'b1;
    bus(1'b1, `OFS_CONTROL_ONE, 8'h54);
    rd(`OFS_FLAG_STATUS, 8'h20); // Fault cleared
    tally_and_finish();
  end
endmodule
